// [shared/accept_flags_defines.svh]
`ifndef ACCEPT_FLAGS_DEFINES_SVH
`define ACCEPT_FLAGS_DEFINES_SVH

// ----------------------------------------
// Register map (byte addresses)
// ----------------------------------------
`define ADDR_FLAGS 8'h00
`define ADDR_STATUS 8'h04
`define ADDR_TRAP 8'h08
`define ADDR_BANK_BASE 8'h40
`define ADDR_BANK_LAST 8'h7C

// ----------------------------------------
// Flag word layout
// ----------------------------------------
`define BIT_MASK 0
`define BIT_STACK 1
`define BIT_RSVD 2
`define IPL_LO 4
`define IPL_HI 6
`define BIT_BANK 7

// ----------------------------------------
// Bank word index and byte lanes
// ----------------------------------------
`define IDX_TOP 7
`define IDX_HI 4
`define IDX_LO 2
`define LANE0 7:0
`define LANE1 15:8

// ----------------------------------------
// Reset values and misc
// ----------------------------------------
`define RST_MASK 1'b0
`define RST_STACK 1'b0
`define RST_BANK 1'b0
`define RST_IPL 3'h0
`define TRAP_LAST 6'h1F
`define RESP_OKAY 2'h0
`define RESP_SLVERR 2'h2
`define REG_RESET 16'h0000

`endif

// [shared/accept_flags_pkg.sv]
package accept_flags_pkg;

	typedef logic [2:0] level_t;
	typedef logic [15:0] word_t;

	typedef enum logic [2:0] {
		DATA_REG_ZERO,
		DATA_REG_ONE,
		DATA_REG_TWO,
		DATA_REG_THREE,
		ADDRESS_REG_ZERO,
		ADDRESS_REG_ONE,
		FRAME_BASE_REG
	} bank_reg_e;

endpackage : accept_flags_pkg

// [rtl/interrupt_accept_flags.sv]
`timescale 1ns/1ps
`include "accept_flags_defines.svh"

module interrupt_accept_flags #(
	parameter int NUM_REGS = 7
) (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic [7:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [7:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	input wire logic irq_req,
	input wire logic [2:0] irq_level,
	input wire logic maskable,
	input wire logic insn_boundary,
	input wire logic trap_exec,
	input wire logic [5:0] trap_num,
	input wire logic [15:0] handler_stack_pointer,
	input wire logic [15:0] task_stack_pointer,
	output logic irq_ack,
	output logic [15:0] stack_pointer,
	output logic stack_select,
	output logic mask_flag,
	output logic [2:0] processor_priority_level
);

	// ----------------------------------------
	// State
	// ----------------------------------------
	// Flag and bank state
	logic mask_ff, nxt_mask;
	logic stack_ff, nxt_stack;
	logic bank_ff, nxt_bank;
	accept_flags_pkg::level_t ipl_ff, nxt_ipl;
	logic ack_ff, nxt_ack;
	logic [5:0] trap_seen_ff, nxt_trap_seen;
	accept_flags_pkg::word_t regs_ff [2][NUM_REGS];
	accept_flags_pkg::word_t nxt_regs [2][NUM_REGS];

	// Bus channel state
	logic aw_ff, nxt_aw, w_ff, nxt_w, b_ff, nxt_b, r_ff, nxt_r;
	logic [7:0] awaddr_ff, nxt_awaddr;
	logic [31:0] wdata_ff, nxt_wdata;
	logic [3:0] wstrb_ff, nxt_wstrb;
	logic [1:0] bresp_ff, nxt_bresp, rresp_ff, nxt_rresp;
	logic [31:0] rdata_ff, nxt_rdata;

	// Decode and helper terms
	logic accept, trap_low, do_write;
	logic wr_bank_hit, rd_bank_hit;
	logic [7:0] widx, ridx;
	logic [31:0] flag_word;

	// ----------------------------------------
	// Acceptance
	// ----------------------------------------
	// Non-maskable requests bypass the mask flag but not the level test
	always_comb begin
		// Ack term keeps one accept per acknowledge pulse
		accept = insn_boundary && irq_req && !ack_ff
			&& (mask_ff || !maskable)
			&& (irq_level > ipl_ff);
		// Traps above the low range leave the select alone
		trap_low = insn_boundary && trap_exec
			&& (trap_num <= `TRAP_LAST);
	end

	// Reserved bit reads zero; software must write it zero
	always_comb begin
		flag_word = '0;
		flag_word[`BIT_MASK] = mask_ff;
		flag_word[`BIT_STACK] = stack_ff;
		flag_word[`BIT_RSVD] = 1'b0;
		flag_word[`IPL_HI:`IPL_LO] = ipl_ff;
		flag_word[`BIT_BANK] = bank_ff;
	end

	// ----------------------------------------
	// AXI4-Lite write path
	// ----------------------------------------
	// Ready drops while a response waits: one write in flight
	assign s_axi_awready = !aw_ff && !b_ff;
	assign s_axi_wready = !w_ff && !b_ff;
	assign s_axi_bvalid = b_ff;
	assign s_axi_bresp = bresp_ff;
	assign do_write = aw_ff && w_ff && !b_ff;
	assign widx = awaddr_ff - `ADDR_BANK_BASE;
	// Bank window hits only words with storage behind them
	assign wr_bank_hit = awaddr_ff >= `ADDR_BANK_BASE
		&& awaddr_ff <= `ADDR_BANK_LAST
		&& widx[`IDX_TOP:`IDX_LO] < 6'(NUM_REGS);

	// Address and data latched independently, response after both
	always_comb begin
		nxt_aw = aw_ff;
		nxt_w = w_ff;
		nxt_b = b_ff;
		nxt_awaddr = awaddr_ff;
		nxt_wdata = wdata_ff;
		nxt_wstrb = wstrb_ff;
		nxt_bresp = bresp_ff;
		if (s_axi_awvalid && s_axi_awready) begin
			nxt_aw = 1'b1;
			nxt_awaddr = s_axi_awaddr;
		end
		if (s_axi_wvalid && s_axi_wready) begin
			nxt_w = 1'b1;
			nxt_wdata = s_axi_wdata;
			nxt_wstrb = s_axi_wstrb;
		end
		// Both halves in hand: commit and raise the response
		if (do_write) begin
			nxt_aw = 1'b0;
			nxt_w = 1'b0;
			nxt_b = 1'b1;
			nxt_bresp = `RESP_OKAY;
			// Status and trap words are read-only
			if (awaddr_ff != `ADDR_FLAGS && !wr_bank_hit)
				nxt_bresp = `RESP_SLVERR;
		end
		// Response slot frees once the master takes it
		if (b_ff && s_axi_bready)
			nxt_b = 1'b0;
	end

	// ----------------------------------------
	// Flag and bank update
	// ----------------------------------------
	// Hardware updates win over a software write in the same cycle
	always_comb begin
		nxt_mask = mask_ff;
		nxt_stack = stack_ff;
		nxt_bank = bank_ff;
		nxt_ipl = ipl_ff;
		nxt_regs = regs_ff;
		nxt_trap_seen = trap_seen_ff;
		// Reserved bit has no storage, so a stray one is dropped
		if (do_write && awaddr_ff == `ADDR_FLAGS && wstrb_ff[0]) begin
			nxt_mask = wdata_ff[`BIT_MASK];
			nxt_stack = wdata_ff[`BIT_STACK];
			nxt_ipl = wdata_ff[`IPL_HI:`IPL_LO];
			nxt_bank = wdata_ff[`BIT_BANK];
		end
		// Writes reach only the active bank
		if (do_write && wr_bank_hit) begin
			if (wstrb_ff[0])
				nxt_regs[bank_ff][widx[`IDX_HI:`IDX_LO]][`LANE0] =
					wdata_ff[`LANE0];
			if (wstrb_ff[1])
				nxt_regs[bank_ff][widx[`IDX_HI:`IDX_LO]][`LANE1] =
					wdata_ff[`LANE1];
			// Upper strobes land on no storage and are ignored
		end
		// Trap overrides a software stack write; acknowledge overrides mask, stack and level
		if (trap_low) begin
			nxt_stack = 1'b0;
			nxt_trap_seen = trap_num;
		end
		// Acknowledge and flag updates in one step
		nxt_ack = accept;
		if (accept) begin
			nxt_mask = 1'b0;
			nxt_stack = 1'b0;
			nxt_ipl = irq_level;
		end
	end

	// ----------------------------------------
	// AXI4-Lite read path
	// ----------------------------------------
	// One read in flight; data held until the master takes it
	assign s_axi_arready = !r_ff;
	assign s_axi_rvalid = r_ff;
	assign s_axi_rdata = rdata_ff;
	assign s_axi_rresp = rresp_ff;
	assign ridx = s_axi_araddr - `ADDR_BANK_BASE;
	assign rd_bank_hit = s_axi_araddr >= `ADDR_BANK_BASE
		&& s_axi_araddr <= `ADDR_BANK_LAST
		&& ridx[`IDX_TOP:`IDX_LO] < 6'(NUM_REGS);

	// Bank reads return the active bank only
	always_comb begin
		nxt_r = r_ff;
		nxt_rdata = rdata_ff;
		nxt_rresp = rresp_ff;
		if (s_axi_arvalid && s_axi_arready) begin
			nxt_r = 1'b1;
			nxt_rresp = `RESP_OKAY;
			nxt_rdata = '0;
			if (s_axi_araddr == `ADDR_FLAGS)
				nxt_rdata = flag_word;
			else if (s_axi_araddr == `ADDR_STATUS)
				nxt_rdata = {31'h0, ack_ff};
			else if (s_axi_araddr == `ADDR_TRAP)
				nxt_rdata = {26'h0, trap_seen_ff};
			else if (rd_bank_hit)
				nxt_rdata = {16'h0,
					regs_ff[bank_ff][ridx[`IDX_HI:`IDX_LO]]};
			else // Unmapped: error with zero data
				nxt_rresp = `RESP_SLVERR;
		end else if (r_ff && s_axi_rready) begin
			nxt_r = 1'b0;
		end
	end

	// ----------------------------------------
	// Write channel registers
	// ----------------------------------------
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			aw_ff <= 1'b0;
			w_ff <= 1'b0;
			b_ff <= 1'b0;
			awaddr_ff <= '0;
			wdata_ff <= '0;
			wstrb_ff <= '0;
			bresp_ff <= `RESP_OKAY;
		end else begin
			aw_ff <= nxt_aw;
			w_ff <= nxt_w;
			b_ff <= nxt_b;
			awaddr_ff <= nxt_awaddr;
			wdata_ff <= nxt_wdata;
			wstrb_ff <= nxt_wstrb;
			bresp_ff <= nxt_bresp;
		end
	end

	// ----------------------------------------
	// Flag and bank registers
	// ----------------------------------------
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			mask_ff <= `RST_MASK;
			stack_ff <= `RST_STACK;
			bank_ff <= `RST_BANK;
			ipl_ff <= `RST_IPL;
			ack_ff <= 1'b0;
			trap_seen_ff <= '0;
			regs_ff <= '{default: '{default: `REG_RESET}};
		end else begin
			mask_ff <= nxt_mask;
			stack_ff <= nxt_stack;
			bank_ff <= nxt_bank;
			ipl_ff <= nxt_ipl;
			ack_ff <= nxt_ack;
			trap_seen_ff <= nxt_trap_seen;
			regs_ff <= nxt_regs;
		end
	end

	// ----------------------------------------
	// Read channel registers
	// ----------------------------------------
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			r_ff <= 1'b0;
			rresp_ff <= `RESP_OKAY;
			rdata_ff <= '0;
		end else begin
			r_ff <= nxt_r;
			rresp_ff <= nxt_rresp;
			rdata_ff <= nxt_rdata;
		end
	end

	// ----------------------------------------
	// Outputs
	// ----------------------------------------
	// Flag outputs come straight from their flip-flops
	assign irq_ack = ack_ff;
	assign mask_flag = mask_ff;
	assign stack_select = stack_ff;
	assign processor_priority_level = ipl_ff;
	// Stack mux follows the registered select
	assign stack_pointer = stack_ff ? task_stack_pointer
		: handler_stack_pointer;

endmodule : interrupt_accept_flags

// [dv/accept_checker.sv]
`timescale 1ns/1ps
// ----------------------------
// Accept path checker
// ----------------------------
module accept_checker (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic irq_req,
	input wire logic [2:0] irq_level,
	input wire logic maskable,
	input wire logic insn_boundary,
	input wire logic trap_exec,
	input wire logic [5:0] trap_num,
	input wire logic irq_ack,
	input wire logic stack_select,
	input wire logic mask_flag,
	input wire logic [2:0] processor_priority_level
);
	default clocking @(posedge aclk);
	endclocking
	default disable iff (!aresetn);
	logic take;
	// Whole acceptance test, one boundary at a time
	assign take = insn_boundary && irq_req && !irq_ack &&
		(mask_flag || !maskable) && irq_level > processor_priority_level;
	mask_gate_a: assert property (
		insn_boundary && maskable && !mask_flag |=> !irq_ack) else $error("mask");
	level_gate_a: assert property (
		irq_level <= processor_priority_level |=> !irq_ack) else $error("low");
	accept_now_a: assert property (
		take |=> irq_ack) else $error("no ack");
	ack_cause_a: assert property (
		irq_ack |-> $past(take)) else $error("stray ack");
	ack_pulse_a: assert property (
		irq_ack |=> !irq_ack) else $error("long ack");
	ack_flags_a: assert property (
		irq_ack |-> !mask_flag && !stack_select) else $error("flags");
	level_load_a: assert property (
		irq_ack |-> processor_priority_level == $past(irq_level)) else $error("ipl");
	trap_clear_a: assert property (
		insn_boundary && trap_exec && trap_num <= 6'h1F |=> !stack_select)
		else $error("trap");
endmodule : accept_checker

bind interrupt_accept_flags accept_checker u_chk (.*);

// [dv/request_source.sv]
`timescale 1ns/1ps
// ----------------------------
// Request source model
// ----------------------------
module request_source (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic post,
	input wire logic drop,
	input wire logic [2:0] post_level,
	input wire logic post_maskable,
	input wire logic irq_ack,
	output logic irq_req,
	output logic [2:0] irq_level,
	output logic maskable
);
	// Held pending until acked or dropped; released lines churn
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			{irq_req, irq_level, maskable} <= 5'h00;
		end else if (post) begin
			{irq_req, irq_level, maskable} <= {1'b1, post_level, post_maskable};
		end else if (drop || irq_ack) begin
			{irq_req, irq_level, maskable} <= {1'b0, ~irq_level, ~maskable};
		end
	end
endmodule : request_source

// [dv/interrupt_accept_flags_bench.sv]
`timescale 1ns/1ps
`include "accept_flags_defines.svh"
// ----------------------------
// Accept flags bench
// ----------------------------
module interrupt_accept_flags_bench;
	logic aclk, aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready;
	logic s_axi_arvalid, s_axi_rready, s_axi_awready, s_axi_wready;
	logic s_axi_bvalid, s_axi_arready, s_axi_rvalid, irq_ack, ex, m, mk;
	logic irq_req, maskable, insn_boundary, trap_exec, stack_select;
	logic mask_flag, post, drop, post_maskable, ta, tw, tb;
	logic [7:0] s_axi_awaddr, s_axi_araddr;
	logic [31:0] s_axi_wdata, s_axi_rdata, rd_d;
	logic [3:0] s_axi_wstrb;
	logic [1:0] s_axi_bresp, s_axi_rresp, rd_r, wr_r;
	logic [2:0] irq_level, processor_priority_level, post_level, lv, pl;
	logic [5:0] trap_num, tn, lt;
	logic [15:0] handler_stack_pointer, task_stack_pointer, stack_pointer, v;
	int err_total, checks, cyc;
	interrupt_accept_flags u_dut (.*);
	request_source u_src (.*);
	// Bus clock
	initial begin
		aclk = 1'b0;
		forever #50 aclk = ~aclk;
	end
	function automatic logic [15:0] lfsr(input logic [15:0] x);
		return {x[14:0], x[15] ^ x[13] ^ x[12] ^ x[10]};
	endfunction : lfsr
	task automatic chk(input string n, input logic [31:0] e, g);
		checks++;
		if (g !== e) begin
			err_total++;
			$display("mismatch %s expected %h seen %h", n, e, g);
		end
	endtask : chk
	// Ready sampled settled, released only after the taking edge
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		{s_axi_awaddr, s_axi_wdata} <= {a, d};
		{s_axi_awvalid, s_axi_wvalid} <= 2'h3;
		do begin
			#1;
			{ta, tw, tb, wr_r} = {s_axi_awready, s_axi_wready,
				s_axi_bvalid, s_axi_bresp};
			@(posedge aclk);
			if (ta) s_axi_awvalid <= 1'b0;
			if (tw) s_axi_wvalid <= 1'b0;
		end while (!tb);
	endtask : wr
	task automatic rd(input logic [7:0] a);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		do begin
			#1;
			{ta, tb, rd_d, rd_r} = {s_axi_arready, s_axi_rvalid, s_axi_rdata, s_axi_rresp};
			@(posedge aclk);
			if (ta) s_axi_arvalid <= 1'b0;
		end while (!tb);
	endtask : rd
	task automatic print_verdict;
		$display("checks %0d err_total %0d", checks, err_total);
		if (err_total == 0 && checks > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask : print_verdict
	// Cycle ceiling against hangs
	always @(posedge aclk) begin
		cyc++;
		if (cyc == 5000) begin
			err_total++;
			print_verdict();
		end
	end
	// Register checks, then random accept and trap trials
	initial begin
		{aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_arvalid, post, drop} = '0;
		{insn_boundary, trap_exec, trap_num, post_level, post_maskable} = '0;
		{s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
		{handler_stack_pointer, task_stack_pointer} = '0;
		{s_axi_bready, s_axi_rready, s_axi_wstrb} = '1;
		v = 16'h2F89;
		lt = 6'h00;
		repeat (2) @(posedge aclk);
		aresetn <= 1'b1;
		@(posedge aclk);
		rd(`ADDR_FLAGS);
		chk("flags", 32'h0, rd_d);
		wr(`ADDR_BANK_BASE, 32'hA5C3);
		chk("wr_resp", `RESP_OKAY, wr_r);
		wr(`ADDR_FLAGS, 32'h80);
		rd(`ADDR_BANK_BASE);
		chk("bank1", 32'h0, rd_d);
		wr(`ADDR_FLAGS, 32'h0);
		rd(`ADDR_BANK_BASE);
		chk("bank0", 32'hA5C3, rd_d);
		rd(8'h20);
		chk("unmapped", {30'h0, `RESP_SLVERR}, {rd_d[29:0], rd_r});
		wr(8'h20, 32'h1);
		chk("wr_unmapped", `RESP_SLVERR, wr_r);
		$display("test regs done");
		for (int i = 0; i < 40; i++) begin
			v = lfsr(v);
			{lv, pl, m, mk, tn} = v[13:0];
			if (i < 2) {lv, pl, tn} = i ? 12'h6E0 : 12'hF9F;
			ex = (m || !mk) && lv > pl;
			handler_stack_pointer <= v;
			task_stack_pointer <= ~v;
			wr(`ADDR_FLAGS, {24'h0, 1'b0, pl, 2'h0, 1'b1, m});
			chk("sp", task_stack_pointer, stack_pointer);
			{post, post_level, post_maskable} <= {1'b1, lv, mk};
			@(posedge aclk);
			{post, insn_boundary} <= 2'h1;
			@(posedge aclk);
			insn_boundary <= 1'b0;
			#1;
			chk("ack", ex, irq_ack);
			chk("ipl", ex ? lv : pl, processor_priority_level);
			chk("msk_sel", ex ? 2'h0 : {1'b1, m}, {stack_select, mask_flag});
			chk("sp_sel", {16'h0, ex ? v : ~v}, stack_pointer);
			@(posedge aclk);
			drop <= 1'b1;
			@(posedge aclk);
			drop <= 1'b0;
			wr(`ADDR_FLAGS, 32'h02);
			{trap_num, trap_exec, insn_boundary} <= {tn, 2'h3};
			@(posedge aclk);
			{trap_exec, insn_boundary} <= 2'h0;
			#1;
			chk("trap_sel", tn > 6'h1F, stack_select);
			if (tn <= `TRAP_LAST)
				lt = tn;
			@(posedge aclk);
			rd(`ADDR_TRAP);
			chk("trap_num", {26'h0, lt}, rd_d);
			$display("test %0d done", i);
		end
		print_verdict();
	end
endmodule : interrupt_accept_flags_bench
